// ---- bench/dior_far_model.sv ----
// Far-side model: switches, sensors and encoder around the I/O router
`timescale 1ns/1ns
`default_nettype none
module dior_far_model (
    input wire logic core_clk,     // System clock
    input wire logic [21:0] lvl,   // Levels: enc, hall, phys
    input wire logic glitch,       // One-cycle flip of input 1
    output logic [15:0] phys_in,   // Physical input lines
    output logic [2:0] hall_in,    // Hall sensor lines
    output logic [2:0] enc_in      // Encoder lines
);
    // Lines start low before the first edge
    initial
    begin
        phys_in = 16'h0000;
        hall_in = 3'h0;
        enc_in = 3'h0;
    end

    // Sensors settle on levels just after an edge; a glitch bounces input 1
    always @(posedge core_clk)
    begin
        phys_in <= lvl[15:0] ^ {15'h0000, glitch};
        hall_in <= lvl[18:16];
        enc_in <= lvl[21:19];
    end
endmodule
`default_nettype wire

// ---- bench/dior_top_tb.sv ----
// Self-checking bench of the digital I/O router
`timescale 1ns/1ns
`default_nettype none
`include "dior_map.svh"
module dior_top_tb;
    localparam int SC = 8;          // Short sample period
    localparam int WT = 3 * SC + 4; // Settling after an input change
    logic core_clk, rst_n = 1'b0, glitch = 1'b0, drive_error = 1'b0; // Clock and controls
    logic [21:0] lvl = 22'h0;       // Far-side levels
    logic [15:0] phys_in, legacy_in_word = 16'h0; // Input pins, legacy word
    logic [2:0] hall_in, enc_in;    // Sensor lines
    logic [31:0] routed_out = 32'h0, wdata = 32'h0, rdata; // Routed sources, bus data
    logic [11:0] awaddr = 12'h0, araddr = 12'h0; // Bus addresses
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready, bvalid; // Write side
    logic arvalid = 1'b0, rready = 1'b0, arready, rvalid; // Read side
    logic [1:0] bresp, rresp;       // Responses
    logic [15:0] out_level;         // Output levels
    logic brake_out, interlock_fault, led_green, led_red; // Other outputs
    int miscompares = 0, total_checks = 0; // Tallies

    dior_far_model far (.core_clk(core_clk), .lvl(lvl), .glitch(glitch),
        .phys_in(phys_in), .hall_in(hall_in), .enc_in(enc_in));

    dior_top #(.SAMPLE_CYCLES(SC), .LED_HALF_CYCLES(4)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .phys_in(phys_in), .hall_in(hall_in),
        .enc_in(enc_in), .legacy_in_word(legacy_in_word), .routed_out(routed_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_error(drive_error),
        .out_level(out_level), .brake_out(brake_out), .interlock_fault(interlock_fault),
        .led_green(led_green), .led_red(led_red));

    // 50 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic test_done;
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t ns: saw %h want %h", $time, seen, exp);
            miscompares++;
        end
    endtask

    // Ends the run when a bus answer never came
    task automatic limit(input int n);
        if (n >= 50)
        begin
            miscompares++;
            $display("unexpected at %0t ns: no bus answer", $time);
            test_done;
        end
    endtask

    // One write; address and data are released as each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        bit aw = 0;
        bit w = 0;
        @(posedge core_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50)
        begin
            @(posedge core_clk);
            n++;
            if (aw && w && bvalid === 1'b1)
                break;
            if (!aw && awready === 1'b1)
            begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1)
            begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        r = bresp;
        bready <= 1'b0;
        limit(n);
    endtask

    // One read; data and response taken with rvalid
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        bit ar = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50)
        begin
            @(posedge core_clk);
            n++;
            if (ar && rvalid === 1'b1)
                break;
            if (!ar && arready === 1'b1)
            begin
                ar = 1;
                arvalid <= 1'b0;
            end
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        limit(n);
    endtask

    // Write expecting OKAY
    task automatic wk(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(32'(r), 32'h0);
    endtask

    // Read expecting OKAY, compared under a mask
    task automatic rk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(32'(r), 32'h0);
        chk(d & m, e & m);
    endtask

    // Expected value of a selector code; v holds enc, hall, phys
    function automatic logic src(input logic [7:0] c, input logic [21:0] v);
        logic [6:0] s = c[6:0];
        if (s == 7'h00)
            return c[7];
        if (s >= 7'h01 && s <= 7'h10)
            return v[s - 7'h01] ^ c[7];
        if (s >= 7'h41 && s <= 7'h46)
            return v[s - 7'h41 + 16] ^ c[7];
        return 1'b0;
    endfunction

    // Blink state of a count of high cycles out of 16
    function automatic logic [1:0] st(input int n);
        return (n == 0) ? 2'h0 : (n < 16) ? 2'h1 : 2'h2;
    endfunction

    // Reset values, read-back, reserved and unmapped space
    task automatic sc_regs;
        logic [11:0] o[6] = '{`DIOR_OFF_OUT_POL, `DIOR_OFF_OUT_FEN, `DIOR_OFF_OUT_FVAL,
            `DIOR_OFF_OUT_ROUTE, `DIOR_OFF_LED_EN, `DIOR_OFF_OUT_UNUSED};
        logic [31:0] m[6] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h1, 32'h3, 32'h0};
        logic [31:0] d;
        logic [1:0] r;
        foreach (o[i])
        begin
            rk(o[i], 32'h0, 32'hffffffff);
            wr(o[i], 32'ha5c31e69, r);
            chk(32'(r), (i == 5) ? 32'h2 : 32'h0);
            rk(o[i], 32'ha5c31e69 & m[i], (i == 5) ? 32'hffffffff : m[i]);
            if (i < 5)
                wk(o[i], 32'h0);
        end
        wr(12'h030, 32'h1, r);
        chk(32'(r), 32'h2);
        rd(12'h030, d, r);
        chk(32'(r), 32'h2);
        chk(d, 32'h0);
    endtask

    // Twenty-one selector codes routed to word bit 16, two input patterns
    task automatic sc_sources;
        logic [7:0] c[21] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44,
            8'h45, 8'h46, 8'h80, 8'h81, 8'h90, 8'hc1, 8'hc3, 8'hc6, 8'h11, 8'h40, 8'h47, 8'hc7};
        logic [21:0] v;
        wk(`DIOR_OFF_IN_ROUTE, 32'h1);
        wk(`DIOR_OFF_SEL_BASE, 32'h80);
        wk(`DIOR_OFF_SEL_BASE + 12'h018, 32'h80);
        wk(`DIOR_OFF_SEL_BASE + 12'h01c, 32'h20);
        for (int k = 0; k < 2; k++)
        begin
            v = k ? 22'h2aaaaa : 22'h155555;
            lvl <= v;
            foreach (c[i])
            begin
                wk(`DIOR_OFF_SEL_BASE + 12'h040, 32'(c[i]));
                repeat (WT) @(posedge core_clk);
                rk(`DIOR_OFF_IN_WORD, {15'h0, src(c[i], v), 16'h41}, 32'h100e1);
            end
        end
        wk(`DIOR_OFF_IN_ROUTE, 32'h0);
        legacy_in_word <= 16'h1234;
        repeat (WT) @(posedge core_clk);
        rk(`DIOR_OFF_IN_WORD, 32'haaaa1234, 32'hffffffff);
    endtask

    // Interlock release routed from input 4
    task automatic sc_interlock;
        wk(`DIOR_OFF_IN_ROUTE, 32'h1);
        wk(`DIOR_OFF_SEL_BASE + 12'h00c, 32'h04);
        lvl <= 22'h0;
        repeat (WT) @(posedge core_clk);
        chk(32'(interlock_fault), 32'h0);
        wk(`DIOR_OFF_IN_SFMASK, 32'h8);
        repeat (WT) @(posedge core_clk);
        chk(32'(interlock_fault), 32'h1);
        rk(`DIOR_OFF_STATUS, 32'h1, 32'h1);
        lvl <= 22'h8;
        repeat (WT) @(posedge core_clk);
        chk(32'(interlock_fault), 32'h0);
        wk(`DIOR_OFF_SEL_BASE + 12'h00c, 32'h84);
        repeat (WT) @(posedge core_clk);
        chk(32'(interlock_fault), 32'h1);
        wk(`DIOR_OFF_IN_SFMASK, 32'h0);
        wk(`DIOR_OFF_IN_ROUTE, 32'h0);
    endtask

    // Command, polarity, force and routing at pins and readback
    task automatic sc_outputs;
        logic [31:0] t[5][6] = '{
            '{32'h00010001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0},
            '{32'h80020000, 32'h00020000, 32'h0, 32'h0, 32'h0, 32'h0},
            '{32'hffffffff, 32'h00040000, 32'h00050001, 32'h00040000, 32'h0, 32'h0},
            '{32'h0, 32'h0, 32'h01000000, 32'h01000000, 32'h1, 32'h0f0f0001},
            '{32'h0000fffe, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0}};
        logic [31:0] e;
        foreach (t[i])
        begin
            routed_out <= t[i][5];
            wk(`DIOR_OFF_OUT_CMD, t[i][0]);
            wk(`DIOR_OFF_OUT_POL, t[i][1]);
            wk(`DIOR_OFF_OUT_FEN, t[i][2]);
            wk(`DIOR_OFF_OUT_FVAL, t[i][3]);
            wk(`DIOR_OFF_OUT_ROUTE, t[i][4]);
            repeat (3) @(posedge core_clk);
            e = (t[i][2] & t[i][3]) | (~t[i][2] & (t[i][4][0] ? t[i][5] : t[i][0]));
            e = e ^ t[i][1];
            chk({out_level, 15'h0, brake_out}, e & 32'hffff0001);
            rk(`DIOR_OFF_OUT_APPLIED, e, 32'hffff0001);
        end
        wk(`DIOR_OFF_OUT_ROUTE, 32'h0);
    endtask

    // LED enables against the error state
    task automatic sc_leds;
        int g;
        int rc;
        for (int k = 0; k < 8; k++)
        begin
            wk(`DIOR_OFF_LED_EN, 32'(k[1:0]));
            drive_error <= k[2];
            g = 0;
            rc = 0;
            repeat (2) @(posedge core_clk);
            repeat (16)
            begin
                @(posedge core_clk);
                g += (led_green === 1'b1) ? 1 : (led_green === 1'b0) ? 0 : 99;
                rc += (led_red === 1'b1) ? 1 : (led_red === 1'b0) ? 0 : 99;
            end
            chk(32'({st(g), st(rc)}), 32'({1'b0, k[0] & ~k[2], 1'b0, k[1] & k[2]}));
        end
        drive_error <= 1'b0;
    endtask

    // Short pulse dropped, lasting level taken
    task automatic sc_filter;
        lvl <= 22'h0;
        repeat (WT) @(posedge core_clk);
        glitch <= 1'b1;
        @(posedge core_clk);
        glitch <= 1'b0;
        repeat (WT) @(posedge core_clk);
        rk(`DIOR_OFF_IN_WORD, 32'h0, 32'h10000);
        lvl <= 22'h1;
        repeat (WT) @(posedge core_clk);
        rk(`DIOR_OFF_IN_WORD, 32'h10000, 32'h10000);
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        sc_regs;
        sc_sources;
        sc_interlock;
        sc_outputs;
        sc_leds;
        sc_filter;
        test_done;
    end
endmodule
`default_nettype wire

// ---- rtl/dior_map.svh ----
// Offsets, field positions and timing counts of the digital I/O router
`ifndef DIOR_MAP_SVH
`define DIOR_MAP_SVH
`define DIOR_OFF_IN_WORD 12'h000
`define DIOR_OFF_OUT_CMD 12'h004
`define DIOR_OFF_OUT_UNUSED 12'h008
`define DIOR_OFF_OUT_POL 12'h00c
`define DIOR_OFF_OUT_FEN 12'h010
`define DIOR_OFF_OUT_FVAL 12'h014
`define DIOR_OFF_OUT_APPLIED 12'h018
`define DIOR_OFF_OUT_ROUTE 12'h01c
`define DIOR_OFF_LED_EN 12'h020
`define DIOR_OFF_IN_SFMASK 12'h024
`define DIOR_OFF_IN_ROUTE 12'h028
`define DIOR_OFF_STATUS 12'h02c
`define DIOR_OFF_SEL_BASE 12'h100
`define DIOR_BIT_INTERLOCK 3
`define DIOR_BIT_BRAKE 0
`define DIOR_BIT_OUT_FIRST 16
`define DIOR_BIT_LED_GREEN 0
`define DIOR_BIT_LED_RED 1
`define DIOR_SEL_INV_BIT 7
`define DIOR_SRC_PHYS_LAST 7'h10
`define DIOR_SRC_HALL_U 7'h41
`define DIOR_SRC_ENC_IDX 7'h46
`define DIOR_SAMPLE_PERIOD_US 1000
`define DIOR_CLK_MHZ 50
`define DIOR_SAMPLE_CYCLES (`DIOR_SAMPLE_PERIOD_US * `DIOR_CLK_MHZ)
`define DIOR_LED_HALF_MS 250
`endif

// ---- rtl/dior_pkg.sv ----
// Types shared by the digital I/O router
package dior_pkg;
    typedef enum logic [1:0] {
        DIOR_WR_IDLE,
        DIOR_WR_RESP
    } dior_wr_state_t;
endpackage

// ---- rtl/dior_top.sv ----
// Digital I/O router: input source selection, interlock, output conditioning, LEDs
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "dior_map.svh"
// Contract
// - One source selector per input word bit
// - Codes select zero, physical, hall, encoder
// - Bit seven inverts source; 0x80 gives one
// - Selector 0x11 routes input word bit 16; the code decodes 0x11 to zero instead
// - Interlock low bit three raises error
// - Interlock active only with mask bit three
// - Interlock signal is routed bit three
// - Output k driven from bit 15+k
// - Output bit zero drives brake only
// - Config bits affect own output only
// - Polarity bit inverts command drive
// - Force enable selects force value
// - Force value holds level per bit
// - Applied outputs readable in readback
// - Routing switch enables routed outputs
// - LED enables for green and red
// - Selectors act only when routing on
// - Inputs sampled every millisecond, short pulses dropped
module dior_top
    import dior_pkg::*;
#(
    parameter int NUM_OUT = 16,                       // Physical outputs
    parameter int SAMPLE_CYCLES = `DIOR_SAMPLE_CYCLES, // Cycles per input sample
    parameter int LED_HALF_CYCLES = `DIOR_LED_HALF_MS * 1000 * `DIOR_CLK_MHZ // LED blink half period
)(
    input wire logic core_clk,             // System clock, 50 MHz
    input wire logic rst_n,                // Synchronous reset, active low
    input wire logic [15:0] phys_in,       // Physical inputs 1..16 (bit 0 = input 1)
    input wire logic [2:0] hall_in,        // Hall U, V, W
    input wire logic [2:0] enc_in,         // Encoder A, B, Index
    input wire logic [15:0] legacy_in_word, // Input word bits used while routing is off
    input wire logic [31:0] routed_out,    // Routed output sources, used when routing is on
    input wire logic [11:0] s_axi_awaddr,  // AXI write address
    input wire logic s_axi_awvalid,        // AXI write address valid
    output logic s_axi_awready,            // AXI write address ready
    input wire logic [31:0] s_axi_wdata,   // AXI write data
    input wire logic [3:0] s_axi_wstrb,    // AXI write strobes
    input wire logic s_axi_wvalid,         // AXI write data valid
    output logic s_axi_wready,             // AXI write data ready
    output logic [1:0] s_axi_bresp,        // AXI write response
    output logic s_axi_bvalid,             // AXI write response valid
    input wire logic s_axi_bready,         // AXI write response ready
    input wire logic [11:0] s_axi_araddr,  // AXI read address
    input wire logic s_axi_arvalid,        // AXI read address valid
    output logic s_axi_arready,            // AXI read address ready
    output logic [31:0] s_axi_rdata,       // AXI read data
    output logic [1:0] s_axi_rresp,        // AXI read response
    output logic s_axi_rvalid,             // AXI read data valid
    input wire logic s_axi_rready,         // AXI read data ready
    input wire logic drive_error,          // Drive in error state (from controller)
    output logic [NUM_OUT-1:0] out_level,  // Applied output levels
    output logic brake_out,                // Applied brake level
    output logic interlock_fault,          // Interlock demands error state and fault reaction
    output logic led_green,                // Green LED drive
    output logic led_red                   // Red LED drive
);
    localparam int NSRC = 32; // Selector entries for input word bits 0..31

    // Input synchroniser stages and sampled copy
    logic [21:0] sync1_ff;
    logic [21:0] sync2_ff;
    logic [21:0] sync3_ff;
    logic [21:0] sampled_ff;
    logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt_ff;
    logic tick_ff;
    // Registers
    logic [7:0] sel_ff [NSRC];
    logic [31:0] out_cmd_ff;
    logic [31:0] pol_ff;
    logic [31:0] fen_ff;
    logic [31:0] fval_ff;
    logic out_route_ff;
    logic [1:0] led_en_ff;
    logic [31:0] in_sfmask_ff;
    logic in_route_ff;
    logic [31:0] in_word_ff;
    logic [31:0] applied_ff;
    logic fault_ff;
    // Bus state and LED blink timebase
    dior_wr_state_t wr_state_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [1:0] bresp_ff;
    logic [$clog2(LED_HALF_CYCLES)-1:0] led_cnt_ff;
    logic blink_ff;

    // Three-stage synchroniser on the physical, hall and encoder inputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sync1_ff <= 22'h0;
            sync2_ff <= 22'h0;
            sync3_ff <= 22'h0;
        end
        else
        begin
            sync1_ff <= {enc_in, hall_in, phys_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Millisecond sample tick
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || tick_cnt_ff == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1))
        begin
            tick_cnt_ff <= '0;
            tick_ff <= rst_n;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    // Sample only where stages 2 and 3 agree; pulses between ticks are lost
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            sampled_ff <= 22'h0;
        else if (tick_ff)
            sampled_ff <= (sync2_ff & sync3_ff) | (sampled_ff & (sync2_ff | sync3_ff));
    end

    // Source decode for one selector code
    function automatic logic src_pick(input logic [7:0] code, input logic [21:0] s);
        logic [6:0] idx;
        idx = code[6:0];
        if (idx == 7'h00)
            src_pick = code[`DIOR_SEL_INV_BIT];
        else if (idx <= `DIOR_SRC_PHYS_LAST)
            src_pick = s[idx[3:0] - 4'h1] ^ code[`DIOR_SEL_INV_BIT];
        else if (idx >= `DIOR_SRC_HALL_U && idx <= `DIOR_SRC_ENC_IDX)
            src_pick = s[5'd16 + 5'(idx - `DIOR_SRC_HALL_U)] ^ code[`DIOR_SEL_INV_BIT];
        else
            src_pick = 1'b0;
    endfunction

    // Input word assembly, once per sample tick
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            in_word_ff <= 32'h0;
        else if (tick_ff)
        begin
            for (int n = 0; n < NSRC; n++)
            begin
                if (in_route_ff)
                    in_word_ff[n] <= src_pick(sel_ff[n], sampled_ff);
                else if (n < 16)
                    in_word_ff[n] <= legacy_in_word[n];
                else
                    in_word_ff[n] <= sampled_ff[n-16];
            end
        end
    end

    // Interlock: bit 3 of the input word releases motion when enabled
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            fault_ff <= 1'b0;
        else
            fault_ff <= in_sfmask_ff[`DIOR_BIT_INTERLOCK] && !in_word_ff[`DIOR_BIT_INTERLOCK];
    end
    assign interlock_fault = fault_ff;

    // Output conditioning per bit: force choice, then polarity
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            applied_ff <= 32'h0;
        else
        begin
            for (int b = 0; b < 32; b++)
            begin
                logic cmd;
                cmd = out_route_ff ? routed_out[b] : out_cmd_ff[b];
                if (fen_ff[b])
                    cmd = fval_ff[b];
                applied_ff[b] <= cmd ^ pol_ff[b];
            end
        end
    end
    assign brake_out = applied_ff[`DIOR_BIT_BRAKE];
    assign out_level = applied_ff[`DIOR_BIT_OUT_FIRST +: NUM_OUT];

    // LED blink timebase
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || led_cnt_ff == ($clog2(LED_HALF_CYCLES))'(LED_HALF_CYCLES - 1))
        begin
            led_cnt_ff <= '0;
            blink_ff <= rst_n ? ~blink_ff : 1'b0;
        end
        else
            led_cnt_ff <= led_cnt_ff + 1'b1;
    end
    assign led_green = led_en_ff[`DIOR_BIT_LED_GREEN] && !drive_error && blink_ff;
    assign led_red = led_en_ff[`DIOR_BIT_LED_RED] && drive_error && blink_ff;

    // Write channel: capture address and data in either order, then respond
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_state_ff <= DIOR_WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bresp_ff <= 2'h0;
        end
        else
        begin
            unique case (wr_state_ff)
                DIOR_WR_IDLE:
                begin
                    if (s_axi_awvalid && !aw_got_ff)
                    begin
                        aw_got_ff <= 1'b1;
                        awaddr_ff <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && !w_got_ff)
                    begin
                        w_got_ff <= 1'b1;
                        wdata_ff <= s_axi_wdata;
                        wstrb_ff <= s_axi_wstrb;
                    end
                    if (aw_got_ff && w_got_ff)
                    begin
                        wr_state_ff <= DIOR_WR_RESP;
                        bresp_ff <= wr_ok(awaddr_ff) ? 2'h0 : 2'h2;
                    end
                end
                DIOR_WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_ff <= DIOR_WR_IDLE;
                        aw_got_ff <= 1'b0;
                        w_got_ff <= 1'b0;
                    end
                end
            endcase
        end
    end
    assign s_axi_awready = (wr_state_ff == DIOR_WR_IDLE) && !aw_got_ff;
    assign s_axi_wready = (wr_state_ff == DIOR_WR_IDLE) && !w_got_ff;
    assign s_axi_bvalid = (wr_state_ff == DIOR_WR_RESP);
    assign s_axi_bresp = bresp_ff;

    // Writable address check
    function automatic logic wr_ok(input logic [11:0] a);
        wr_ok = (a == `DIOR_OFF_OUT_CMD) || (a == `DIOR_OFF_OUT_POL) || (a == `DIOR_OFF_OUT_FEN)
            || (a == `DIOR_OFF_OUT_FVAL) || (a == `DIOR_OFF_OUT_ROUTE) || (a == `DIOR_OFF_LED_EN)
            || (a == `DIOR_OFF_IN_SFMASK) || (a == `DIOR_OFF_IN_ROUTE)
            || (a[11:8] == 4'(`DIOR_OFF_SEL_BASE >> 8) && a[1:0] == 2'h0 && a[7:2] < 6'(NSRC));
    endfunction

    // Merge byte lanes
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        lanes = old;
    endfunction

    // Register updates on the write commit cycle
    logic wr_commit;
    assign wr_commit = (wr_state_ff == DIOR_WR_IDLE) && aw_got_ff && w_got_ff;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            out_cmd_ff <= 32'h0;
            pol_ff <= 32'h0;
            fen_ff <= 32'h0;
            fval_ff <= 32'h0;
            out_route_ff <= 1'b0;
            led_en_ff <= 2'h0;
            in_sfmask_ff <= 32'h0;
            in_route_ff <= 1'b0;
            for (int n = 0; n < NSRC; n++)
                sel_ff[n] <= 8'h00;
        end
        else if (wr_commit)
        begin
            unique case (awaddr_ff)
                `DIOR_OFF_OUT_CMD: out_cmd_ff <= lanes(out_cmd_ff, wdata_ff, wstrb_ff);
                `DIOR_OFF_OUT_POL: pol_ff <= lanes(pol_ff, wdata_ff, wstrb_ff);
                `DIOR_OFF_OUT_FEN: fen_ff <= lanes(fen_ff, wdata_ff, wstrb_ff);
                `DIOR_OFF_OUT_FVAL: fval_ff <= lanes(fval_ff, wdata_ff, wstrb_ff);
                `DIOR_OFF_OUT_ROUTE: if (wstrb_ff[0]) out_route_ff <= wdata_ff[0];
                `DIOR_OFF_LED_EN: if (wstrb_ff[0]) led_en_ff <= wdata_ff[1:0];
                `DIOR_OFF_IN_SFMASK: in_sfmask_ff <= lanes(in_sfmask_ff, wdata_ff, wstrb_ff);
                `DIOR_OFF_IN_ROUTE: if (wstrb_ff[0]) in_route_ff <= wdata_ff[0];
                default:
                    if (wr_ok(awaddr_ff) && wstrb_ff[0])
                        sel_ff[awaddr_ff[6:2]] <= wdata_ff[7:0];
            endcase
        end
    end

    // Read channel: one-cycle latency, SLVERR on unmapped
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'h0;
        end
        else if (rvalid_ff)
        begin
            if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= 2'h0;
            unique case (s_axi_araddr)
                `DIOR_OFF_IN_WORD: rdata_ff <= in_word_ff;
                `DIOR_OFF_OUT_CMD: rdata_ff <= out_cmd_ff;
                `DIOR_OFF_OUT_UNUSED: rdata_ff <= 32'h0;
                `DIOR_OFF_OUT_POL: rdata_ff <= pol_ff;
                `DIOR_OFF_OUT_FEN: rdata_ff <= fen_ff;
                `DIOR_OFF_OUT_FVAL: rdata_ff <= fval_ff;
                `DIOR_OFF_OUT_APPLIED: rdata_ff <= applied_ff;
                `DIOR_OFF_OUT_ROUTE: rdata_ff <= {31'h0, out_route_ff};
                `DIOR_OFF_LED_EN: rdata_ff <= {30'h0, led_en_ff};
                `DIOR_OFF_IN_SFMASK: rdata_ff <= in_sfmask_ff;
                `DIOR_OFF_IN_ROUTE: rdata_ff <= {31'h0, in_route_ff};
                `DIOR_OFF_STATUS: rdata_ff <= {31'h0, fault_ff};
                default:
                begin
                    if (wr_ok(s_axi_araddr))
                        rdata_ff <= {24'h0, sel_ff[s_axi_araddr[6:2]]};
                    else
                    begin
                        rdata_ff <= 32'h0;
                        rresp_ff <= 2'h2;
                    end
                end
            endcase
        end
    end
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Checks, all on the core clock and quiet during reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_interlock;
        (in_sfmask_ff[3] && !in_word_ff[3]) |=> interlock_fault;
    endproperty
    a_interlock: assert property (p_interlock) else $error("interlock not raised");
    property p_interlock_off;
        !in_sfmask_ff[3] |=> !interlock_fault;
    endproperty
    a_interlock_off: assert property (p_interlock_off) else $error("interlock while off");
    property p_force;
        fen_ff[16] |=> (out_level[0] == ($past(fval_ff[16]) ^ $past(pol_ff[16])));
    endproperty
    a_force: assert property (p_force) else $error("forced output wrong");
    property p_brake;
        (!fen_ff[0] && !out_route_ff) |=> (brake_out == ($past(out_cmd_ff[0]) ^ $past(pol_ff[0])));
    endproperty
    a_brake: assert property (p_brake) else $error("brake level wrong");
    property p_pol;
        (!fen_ff[17] && !out_route_ff && pol_ff[17] && out_cmd_ff[17]) |=> !out_level[1];
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not applied");
    property p_zero_code;
        (tick_ff && in_route_ff && sel_ff[5] == 8'h00) |=> !in_word_ff[5];
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("code zero not zero");
    property p_one_code;
        (tick_ff && in_route_ff && sel_ff[6] == 8'h80) |=> in_word_ff[6];
    endproperty
    a_one_code: assert property (p_one_code) else $error("code 0x80 not one");
    property p_hold;
        !tick_ff |=> $stable(in_word_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("input word moved off tick");
    property p_bad_code;
        (tick_ff && in_route_ff && sel_ff[7] == 8'h20) |=> !in_word_ff[7];
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("unlisted code not zero");
endmodule
`default_nettype wire
